// [rtl/rth_led.sv]
// status led pattern generator
`default_nettype none
module rth_led #(
    parameter int SLOW_HALF = rth_pkg::SLOW_HALF_CYC,
    parameter int FAST_HALF = rth_pkg::FAST_HALF_CYC
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic running,
    input  wire logic touch,
    input  wire logic spi_mode,
    output logic      led
);
    //==============================================================
    // counter
    initial begin
        if (SLOW_HALF < 2 || FAST_HALF < 1 || FAST_HALF >= SLOW_HALF) $error("rth_led: bad half periods");
    end
    logic [31:0] cnt;
    logic        slow_ph;
    logic        fast_ph;
    wire         fast_end = (cnt % 32'(FAST_HALF)) == 32'(FAST_HALF - 1);
    wire         slow_end = cnt == 32'(SLOW_HALF - 1);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt     <= '0;
            slow_ph <= 1'b0;
            fast_ph <= 1'b0;
            led     <= 1'b0;
        end else begin
            cnt     <= slow_end ? '0 : cnt + 32'd1;
            slow_ph <= slow_end ? ~slow_ph : slow_ph;
            fast_ph <= fast_end ? ~fast_ph : fast_ph;
            if (!running) led <= 1'b0;
            else if (touch) led <= fast_ph; // R05
            else if (spi_mode) led <= 1'b0; // R06
            else led <= slow_ph; // R04
        end
    end
    // fast toggle picks touch; led follows it one cycle later
    property p_touch_led;
        @(posedge ref_clk) disable iff (srst)
        (running && touch) |=> (led == $past(fast_ph));
    endproperty
    a_touch_led: assert property (p_touch_led) else $error("led not toggling in touch"); // R05
    property p_spi_off;
        @(posedge ref_clk) disable iff (srst)
        (running && !touch && spi_mode) |=> !led;
    endproperty
    a_spi_off: assert property (p_spi_off) else $error("led lit in spi idle"); // R06
    property p_slow;
        @(posedge ref_clk) disable iff (srst)
        (running && !touch && !spi_mode) |=> (led == $past(slow_ph));
    endproperty
    a_slow: assert property (p_slow) else $error("led not slow flashing"); // R04
endmodule : rth_led
`default_nettype wire

// [rtl/rth_pkg.sv]
// package: constants and carrier types of the touch host i2c port
//==============================================================
// Summary of operation
// R01: sensor strap low selects 4/8-wire, high 5-wire
// R02: 4/8-wire family picks wires from touch options
// R03: 4/8-wire family starts in 4-wire mode
// R04: no touch outside spi: slow led flash
// R05: touch in progress: fast led toggle
// R06: spi host: led off without touch
// R07: i2c slave answers only address 0x4d
// R08: serial clock up to 400 khz supported
// R09: host strap low enables i2c port
// R10: scl and sda driven open-drain only
// R11: write bits sampled on scl rising edge
// R12: read bits change after scl falling edge
// R13: data-ready irq push-pull, low when idle
// R14: data-ready irq high while data waits
// R15: device may hold scl low to stall
// R16: msb first, ack on ninth clock
// R17: sleep discards pending reports and responses; a byte loaded in the sleep_enter cycle is kept
// R18: sda released unless driving ack or data
`default_nettype none
package rth_pkg;
    //==============================================================
    // constants
    localparam logic [6:0] SLAVE_ADDR    = 7'h4d;
    localparam int         CLK_HZ        = 100_000_000;
    localparam int         SLOW_FLASH_MS = 500;
    localparam int         SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_FLASH_MS;
    localparam int         FAST_TGL_US   = 50;
    localparam int         FAST_HALF_CYC = CLK_HZ / 1_000_000 * FAST_TGL_US;
    localparam int         BITS_PER_BYTE = 8;
    localparam int         WIRE_SEL_BIT  = 0;
    //==============================================================
    // types
    typedef enum logic [1:0] {RTH_W4, RTH_W8, RTH_W5} rth_wire_e;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rth_byte_s;
    typedef struct packed {
        logic scl_i;
        logic sda_i;
    } rth_bus_in_s;
endpackage : rth_pkg
`default_nettype wire

// [rtl/rth_port.sv]
// i2c slave host port with straps, data-ready irq and status led
`default_nettype none
module rth_port #(
    parameter int SLOW_HALF = rth_pkg::SLOW_HALF_CYC,
    parameter int FAST_HALF = rth_pkg::FAST_HALF_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              scl_i,
    output logic                   scl_oe_n,
    input  wire logic              sda_i,
    output logic                   sda_oe_n,
    input  wire logic              sensor_type_strap,
    input  wire logic              host_port_strap,
    input  wire logic              touch_options_config,
    input  wire logic              touch_active,
    input  wire logic              sleep_enter,
    input  wire rth_pkg::rth_byte_s tx_load,
    output logic                   tx_ready,
    input  wire logic              tx_stall,
    output rth_pkg::rth_byte_s     rx_out,
    output rth_pkg::rth_wire_e     wire_mode,
    output logic                   i2c_enabled,
    output logic                   data_ready_irq,
    output logic                   led
);
    //==============================================================
    // synchronisers
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] sn_s;
    logic [1:0] hp_s;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            sn_s  <= 2'h0;
            hp_s  <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            sn_s  <= {sn_s[0], sensor_type_strap};
            hp_s  <= {hp_s[0], host_port_strap};
            scl_q <= scl_s[1];
            sda_q <= sda_s[1];
        end
    end
    wire scl     = scl_s[1];
    wire sda     = sda_s[1];
    wire scl_ris = scl && !scl_q; // R11 R08
    wire scl_fal = !scl && scl_q;
    wire start_c = scl && scl_q && sda_q && !sda;
    wire stop_c  = scl && scl_q && !sda_q && sda;
    //==============================================================
    // straps and wire mode
    logic [1:0] strap_cnt;
    logic       sn_l;
    logic       hp_l;
    logic       w8_sel;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_cnt <= 2'h0;
            sn_l      <= 1'b0;
            hp_l      <= 1'b1;
            w8_sel    <= 1'b0; // R03
        end else begin
            if (strap_cnt != 2'h3) strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == 2'h2) begin
                sn_l <= sn_s[1]; // R01
                hp_l <= hp_s[1];
            end
            w8_sel <= touch_options_config; // R02
        end
    end
    wire straps_ok = strap_cnt == 2'h3;
    assign wire_mode   = sn_l ? rth_pkg::RTH_W5 : (w8_sel ? rth_pkg::RTH_W8 : rth_pkg::RTH_W4); // R01 R02 R03
    assign i2c_enabled = straps_ok && !hp_l; // R09
    //==============================================================
    // transfer engine
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WR, S_RD, S_RACK, S_SKIP} rth_st_e;
    rth_st_e    st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       rd;
    logic       drive_low;
    logic       pend;
    logic [7:0] pend_d;
    logic       stretch;
    wire        last_bit  = bitn == 4'(rth_pkg::BITS_PER_BYTE - 1);
    wire        addr_hit  = sh[7:1] == rth_pkg::SLAVE_ADDR; // R07
    // empty slot reads as all ones, so a polling master sees no packet
    wire [7:0]  rd_byte   = pend ? pend_d : 8'hff; // R12
    wire        tx_take   = tx_load.valid && !pend;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st        <= S_IDLE;
            bitn      <= 4'h0;
            sh        <= 8'h00;
            rd        <= 1'b0;
            drive_low <= 1'b0;
            pend      <= 1'b0;
            pend_d    <= 8'h00;
            stretch   <= 1'b0;
            rx_out    <= '0;
        end else begin
            rx_out.valid <= 1'b0;
            if (tx_take) begin
                pend   <= 1'b1; // R14
                pend_d <= tx_load.data;
            end
            if (sleep_enter && !tx_take) pend <= 1'b0; // R17
            // no stall in S_IDLE or S_SKIP; the address byte of any transfer can still be stalled
            stretch <= tx_stall && st != S_IDLE && st != S_SKIP && !scl; // R15
            if (!i2c_enabled || stop_c) begin
                st        <= S_IDLE;
                drive_low <= 1'b0; // R18
            end else if (start_c) begin
                st        <= S_ADDR;
                bitn      <= 4'h0;
                drive_low <= 1'b0;
            end else begin
                case (st)
                    S_ADDR, S_WR: begin
                        if (scl_ris) begin
                            sh   <= {sh[6:0], sda}; // R11 R16
                            bitn <= bitn + 4'h1;
                        end
                        if (scl_fal && bitn == 4'(rth_pkg::BITS_PER_BYTE)) begin
                            if (st == S_ADDR && !addr_hit) begin
                                st <= S_SKIP;
                            end else begin
                                drive_low <= 1'b1; // R16
                                rd        <= (st == S_ADDR) ? sh[0] : 1'b0;
                                if (st == S_WR) rx_out <= '{valid: 1'b1, data: sh};
                                st <= S_ACK;
                            end
                        end
                    end
                    S_ACK: if (scl_fal) begin
                        bitn <= 4'h0;
                        if (rd) begin
                            sh        <= rd_byte;
                            drive_low <= !rd_byte[7]; // R12
                            // a load in this cycle finds pend low and must survive
                            if (pend) pend <= 1'b0;
                            st        <= S_RD;
                        end else begin
                            drive_low <= 1'b0;
                            st        <= S_WR;
                        end
                    end
                    S_RD: if (scl_fal) begin
                        if (last_bit) begin
                            drive_low <= 1'b0; // R18
                            st        <= S_RACK;
                        end else begin
                            drive_low <= !sh[6]; // R12 R16
                            sh        <= {sh[6:0], 1'b1};
                            bitn      <= bitn + 4'h1;
                        end
                    end
                    S_RACK: begin
                        if (scl_ris) rd <= !sda;
                        if (scl_fal) begin
                            bitn <= 4'h0;
                            if (rd) begin
                                sh        <= rd_byte;
                                drive_low <= !rd_byte[7]; // R12 R16
                                if (pend) pend <= 1'b0;
                                st        <= S_RD;
                            end else begin
                                st <= S_SKIP;
                            end
                        end
                    end
                    S_SKIP: drive_low <= 1'b0;
                    default: st <= S_IDLE;
                endcase
            end
        end
    end
    assign tx_ready       = !pend;
    assign data_ready_irq = pend; // R13 R14
    assign sda_oe_n       = !drive_low; // R10 R18
    assign scl_oe_n       = !stretch; // R10 R15
    //==============================================================
    // status led
    rth_led #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_led (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .running  (straps_ok),
        .touch    (touch_active),
        .spi_mode (straps_ok && hp_l),
        .led      (led)
    );
    //==============================================================
    // checks
    property p_addr_ack;
        @(posedge ref_clk) disable iff (srst)
        (st == S_ADDR && scl_fal && bitn == 4'd8 && sh[7:1] != rth_pkg::SLAVE_ADDR) |=> !drive_low;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("acked foreign address"); // R07
    property p_irq;
        @(posedge ref_clk) disable iff (srst)
        tx_take |=> data_ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised"); // R14
    property p_sleep;
        @(posedge ref_clk) disable iff (srst)
        (sleep_enter && !tx_take) |=> !data_ready_irq;
    endproperty
    a_sleep: assert property (p_sleep) else $error("pending data kept over sleep"); // R17
    property p_rd_stable;
        @(posedge ref_clk) disable iff (srst)
        (st == S_RD && scl && scl_q) |-> $stable(drive_low);
    endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read bit moved with scl high"); // R12
    property p_sda_free;
        @(posedge ref_clk) disable iff (srst)
        (st inside {S_IDLE, S_ADDR, S_WR, S_SKIP, S_RACK}) |-> sda_oe_n;
    endproperty
    a_sda_free: assert property (p_sda_free) else $error("sda held outside ack or data"); // R18
    property p_wmode;
        @(posedge ref_clk) disable iff (srst)
        (straps_ok && !sn_l && !w8_sel) |-> wire_mode == rth_pkg::RTH_W4;
    endproperty
    a_wmode: assert property (p_wmode) else $error("not 4-wire by default"); // R03
    property p_i2c_off;
        @(posedge ref_clk) disable iff (srst)
        !i2c_enabled |=> sda_oe_n;
    endproperty
    a_i2c_off: assert property (p_i2c_off) else $error("sda driven with i2c off"); // R09
    property p_w5;
        @(posedge ref_clk) disable iff (srst)
        sn_l |-> wire_mode == rth_pkg::RTH_W5;
    endproperty
    a_w5: assert property (p_w5) else $error("5-wire strap ignored"); // R01
    sequence s_own_addr_end;
        i2c_enabled && st == S_ADDR && scl_fal && bitn == 4'd8 && addr_hit;
    endsequence
    sequence s_ack_driven;
        st == S_ACK && !sda_oe_n;
    endsequence
    property p_addr_match;
        @(posedge ref_clk) disable iff (srst)
        s_own_addr_end |=> s_ack_driven;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("own address not acked"); // R07 R16
endmodule : rth_port
`default_nettype wire

// [test/rth_master.sv]
// i2c bus master partner model, open-drain
`default_nettype none
module rth_master (
    input  wire logic ref_clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_n,
    output logic      sda_n
);
    timeunit 1ns;
    timeprecision 1ps;
    //==============================================================
    // bus timing
    localparam int QTR = 84; // third of a bit: 252 cycles keeps scl under 400 khz
    int glitch = 0;
    initial begin
        scl_n = 1'b1;
        sda_n = 1'b1;
    end
    task automatic q();
        repeat (QTR) @(negedge ref_clk);
    endtask : q
    // release scl and wait out a stretching slave, bounded
    task automatic hi();
        scl_n = 1'b1;
        for (int n = 0; n < 20000 && scl !== 1'b1; n++) @(negedge ref_clk);
    endtask : hi
    task automatic start();
        sda_n = 1'b1;
        scl_n = 1'b1;
        q();
        sda_n = 1'b0;
        q();
        scl_n = 1'b0;
        q();
    endtask : start
    task automatic stop();
        sda_n = 1'b0;
        q();
        hi();
        q();
        sda_n = 1'b1;
        q();
    endtask : stop
    task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r, output logic ra);
        logic [8:0] sh;
        logic       b;
        sh = {w, ak};
        for (int i = 8; i >= 0; i--) begin // msb first, ack as ninth bit
            sda_n = sh[i];
            q();
            hi();
            b = sda;
            q();
            if (sda !== b) glitch++; // slave data must hold over scl high
            scl_n = 1'b0;
            q();
            sh[i] = b;
        end
        r = sh[8:1];
        ra = sh[0];
    endtask : xfer
endmodule : rth_master
`default_nettype wire

// [test/rth_port_tb_top.sv]
// testbench of the touch host i2c port
`default_nettype none
`define chk(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module rth_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    //==============================================================
    // signals
    logic                ref_clk = 1'b0;
    logic                srst, sensor_type_strap, host_port_strap, touch_options_config;
    logic                touch_active, sleep_enter, tx_stall, m_scl_n, m_sda_n;
    logic                scl_oe_n, sda_oe_n, tx_ready, i2c_enabled, data_ready_irq, led, ak;
    logic [7:0]          r;
    rth_pkg::rth_byte_s  tx_load, rx_out;
    rth_pkg::rth_wire_e  wire_mode;
    wire logic           scl = m_scl_n & scl_oe_n; // pulled up, wired and
    wire logic           sda = m_sda_n & sda_oe_n;
    int                  fails = 0, samples_checked = 0, pend = -1, cnt;
    int                  got_q[$];
    // short led periods keep the run brief
    rth_port #(.SLOW_HALF(20), .FAST_HALF(2)) dut (.ref_clk, .srst, .scl_i(scl), .scl_oe_n, .sda_i(sda),
        .sda_oe_n, .sensor_type_strap, .host_port_strap, .touch_options_config, .touch_active,
        .sleep_enter, .tx_load, .tx_ready, .tx_stall, .rx_out, .wire_mode, .i2c_enabled,
        .data_ready_irq, .led);
    rth_master m (.ref_clk, .scl, .sda, .scl_n(m_scl_n), .sda_n(m_sda_n));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (rx_out.valid === 1'b1) got_q.push_back(rx_out.data);
    //==============================================================
    // tasks
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic do_reset();
        srst = 1'b1;
        repeat (16) @(negedge ref_clk);
        `chk({data_ready_irq, sda_oe_n, scl_oe_n}, 3'b011)
        srst = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask : do_reset
    task automatic leds(input int n, output int c);
        logic p;
        c = 0;
        p = led;
        repeat (n) begin
            @(negedge ref_clk);
            if (led !== p) c++;
            p = led;
        end
    endtask : leds
    // one byte slot: a load while one waits is refused
    task automatic load(input logic [7:0] d);
        tx_load = '{valid: 1'b1, data: d};
        if (pend < 0) pend = d;
        @(negedge ref_clk);
        tx_load = '0;
        @(negedge ref_clk);
        `chk(data_ready_irq, 1'b1)
    endtask : load
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        m.start();
        m.xfer({a, 1'b0}, 1'b1, r, ak);
        `chk(ak, a != 7'h4d)
        m.xfer(d, 1'b1, r, ak);
        `chk(ak, a != 7'h4d)
        m.stop();
        `chk(got_q.size(), int'(a == 7'h4d))
        if (a == 7'h4d) `chk(got_q[0], int'(d))
        got_q.delete();
    endtask : wr
    // n bytes: pending byte or all ones first, all ones after, master nacks the last
    task automatic rd(input int n);
        int e;
        e = (pend < 0) ? 8'hff : pend;
        pend = -1;
        m.start();
        m.xfer({7'h4d, 1'b1}, 1'b1, r, ak);
        `chk(ak, 1'b0)
        for (int j = 0; j < n; j++) begin
            m.xfer(8'hff, j == n - 1, r, ak);
            `chk(r, (j == 0) ? e[7:0] : 8'hff)
        end
        m.stop();
        `chk(data_ready_irq, 1'b0)
    endtask : rd
    //==============================================================
    // main sequence
    initial begin
        {sensor_type_strap, host_port_strap, touch_options_config, touch_active} = 4'h0;
        {sleep_enter, tx_stall} = 2'b00;
        tx_load = '0;
        void'($urandom(32'hb607bdbb));
        for (int i = 0; i < 4; i++) begin
            {host_port_strap, sensor_type_strap} = i[1:0];
            touch_options_config = 1'b0;
            do_reset();
            `chk(i2c_enabled, ~host_port_strap)
            `chk(wire_mode, sensor_type_strap ? rth_pkg::RTH_W5 : rth_pkg::RTH_W4)
            touch_options_config = 1'b1;
            @(negedge ref_clk);
            `chk(wire_mode, sensor_type_strap ? rth_pkg::RTH_W5 : rth_pkg::RTH_W8)
            leds(400, cnt);
            `chk(host_port_strap ? cnt == 0 : cnt inside {[15:22]}, 1'b1)
            touch_active = 1'b1;
            leds(400, cnt);
            `chk(cnt inside {[100:201]}, 1'b1)
            touch_active = 1'b0;
        end
        {host_port_strap, sensor_type_strap} = 2'b00;
        do_reset();
        for (int k = 0; k < 3; k++) wr(7'h4d, 8'($urandom));
        wr(7'h4d ^ 7'($urandom_range(1, 127)), 8'($urandom));
        load(8'($urandom));
        load(8'($urandom));
        rd(1);
        rd(2);
        load(8'($urandom));
        sleep_enter = 1'b1;
        @(negedge ref_clk);
        sleep_enter = 1'b0;
        @(negedge ref_clk);
        `chk({data_ready_irq, tx_ready}, 2'b01)
        pend = -1;
        rd(1);
        tx_stall = 1'b1;
        fork
            wr(7'h4d, 8'($urandom));
            begin
                repeat (600) @(negedge ref_clk);
                `chk({scl, scl_oe_n}, 2'b00)
                tx_stall = 1'b0;
            end
        join
        `chk(m.glitch, 0)
        report_and_stop();
    end
    // watchdog, well past the expected half millisecond, under the cycle budget
    initial begin
        #900us;
        fails++;
        report_and_stop();
    end
endmodule : rth_port_tb_top
`default_nettype wire
